// ===== hw/sdb_pkg.sv
// Purpose: shared constants for the spi data buffer block
// Assumes: 32-bit axi4-lite register bus, byte-wide serial transfers
// Notes:   offsets are byte addresses, one aligned word per register
package sdb_pkg;

	// ----------------------------------------------------------------
	// bus and data widths
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned BYTE_W = 8;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_DATA   = 8'h00; // tx write, rx read
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_CTRL   = 8'h0C;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned ST_TXE_BIT = 0;
	localparam int unsigned ST_RXF_BIT = 1;
	localparam int unsigned ST_ACT_BIT = 2;
	localparam int unsigned CT_LSB_BIT = 0;
	localparam int unsigned CT_RCB_BIT = 1;
	localparam logic        TXE_RST    = 1'b1;
	localparam logic        RXF_RST    = 1'b0;
	localparam logic        LSB_RST    = 1'b0;
	localparam logic        RCB_RST    = 1'b0;

	// ----------------------------------------------------------------
	// bus responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// serial timing: link clock cycles per half bit period
	// ----------------------------------------------------------------
	localparam int unsigned HALF_CYC  = 2;
	localparam int unsigned BITS_LAST = 7;

	// shifter states, gray along idle -> low -> high
	typedef enum logic [1:0] {
		SDB_IDLE = 2'h0,
		SDB_LOW  = 2'h1,
		SDB_HIGH = 2'h3
	} sdb_state_e;

endpackage

// ===== hw/sdb_sync.sv
// Purpose: two flop level synchroniser
// Assumes: input is a level or a toggle from another domain
// Notes:   first flop feeds only the second
`timescale 1ns/1ps
module sdb_sync
(
	input  wire logic clk,
	input  wire logic d,
	output logic      q
);
	import sdb_pkg::*;

	logic meta_q;

	// no reset: the bench holds reset long enough to flush these
	always_ff @(posedge clk)
	begin
		meta_q <= d;
		q      <= meta_q;
	end

endmodule

// ===== hw/sdb_shifter.sv
// Purpose: byte shifter on the link clock, mode 0 serial timing
// Assumes: tx byte and order stay stable while a start toggle is seen
// Notes:   done toggle flips once per byte with rx byte already valid
`timescale 1ns/1ps
module sdb_shifter
(
	input  wire logic                      link_clk,
	input  wire logic                      rst_n,
	input  wire logic                      clk_en,
	input  wire logic                      start_tgl,
	input  wire logic [sdb_pkg::BYTE_W-1:0] tx_byte,
	input  wire logic                      lsb_first,
	input  wire logic                      miso,
	output logic                           sclk,
	output logic                           mosi,
	output logic [sdb_pkg::BYTE_W-1:0]     rx_byte,
	output logic                           done_tgl
);
	import sdb_pkg::*;

	logic       lrst_n;
	logic       len;
	logic       start_s;
	logic       miso_s;
	logic       start_prev_q;
	logic       lsb_q;
	logic [2:0] bit_q;
	logic [1:0] half_q;
	logic [7:0] sh_q;
	sdb_state_e state_q;

	// ----------------------------------------------------------------
	// crossings into the link domain
	// ----------------------------------------------------------------
	sdb_sync u_rst   (.clk(link_clk), .d(rst_n),     .q(lrst_n));
	sdb_sync u_en    (.clk(link_clk), .d(clk_en),    .q(len));
	sdb_sync u_start (.clk(link_clk), .d(start_tgl), .q(start_s));
	sdb_sync u_miso  (.clk(link_clk), .d(miso),      .q(miso_s));

	// ----------------------------------------------------------------
	// shift engine: drive on low half, sample at end of high half
	// ----------------------------------------------------------------
	always_ff @(posedge link_clk)
	begin
		if (!lrst_n)
		begin
			state_q      <= SDB_IDLE;
			start_prev_q <= 1'b0;
			lsb_q        <= 1'b0;
			bit_q        <= 3'h0;
			half_q       <= 2'h0;
			sh_q         <= 8'h00;
			rx_byte      <= 8'h00;
			sclk         <= 1'b0;
			mosi         <= 1'b0;
			done_tgl     <= 1'b0;
		end
		else if (len)
		begin
			case (state_q)
				SDB_IDLE:
				begin
					if (start_s != start_prev_q)
					begin
						start_prev_q <= start_s;
						sh_q         <= tx_byte;
						lsb_q        <= lsb_first;
						mosi         <= lsb_first ? tx_byte[0] : tx_byte[7]; // [RULE_16]
						bit_q        <= 3'h0;
						half_q       <= 2'h0;
						state_q      <= SDB_LOW;
					end
				end
				SDB_LOW:
				begin
					half_q <= half_q + 2'h1;
					if (half_q == 2'(HALF_CYC - 1))
					begin
						half_q  <= 2'h0;
						sclk    <= 1'b1;
						state_q <= SDB_HIGH;
					end
				end
				SDB_HIGH:
				begin
					half_q <= half_q + 2'h1;
					if (half_q == 2'(HALF_CYC - 1))
					begin
						half_q <= 2'h0;
						sclk   <= 1'b0;
						// sample whatever the line holds, valid or not
						rx_byte <= lsb_q ? {miso_s, rx_byte[7:1]}
							: {rx_byte[6:0], miso_s}; // [RULE_16]
						sh_q <= lsb_q ? {1'b0, sh_q[7:1]} : {sh_q[6:0], 1'b0};
						if (bit_q == 3'(BITS_LAST))
						begin
							done_tgl <= ~done_tgl; // [RULE_10]
							state_q  <= SDB_IDLE;
						end
						else
						begin
							bit_q   <= bit_q + 3'h1;
							mosi    <= lsb_q ? sh_q[1] : sh_q[6]; // [RULE_16]
							state_q <= SDB_LOW;
						end
					end
				end
				default:
				begin
					state_q <= SDB_IDLE;
				end
			endcase
		end
	end

endmodule

// ===== hw/sdb_top.sv
// Purpose: transmit and receive byte buffers of an spi master
// Assumes: axi4-lite master, one read and one write outstanding
// Notes:   shifting runs on link_clk, buffers and flags on ref_clk
`timescale 1ns/1ps

// Contract
// RULE_01: set rx full when a byte lands in rx holding; clear on its read.
// RULE_02: rx full flag is offered as a receive interrupt request.
// RULE_03: tx empty reads one when tx holding empty, resets one, write clears.
// RULE_04: tx empty flag is offered as a transmit interrupt request.
// RULE_05: a byte written while tx empty is one starts a transfer.
// RULE_06: idle shifter takes the new byte at once and tx empty sets again.
// RULE_07: while shifting, a queued byte waits in tx holding.
// RULE_08: when shifting ends the queued byte loads and tx empty sets.
// RULE_09: firmware must not write tx holding while tx empty is zero.
// RULE_10: every finished byte goes to rx holding and sets rx full.
// RULE_11: firmware reads rx holding only after rx full is set.
// RULE_12: firmware reads rx holding before writing the next tx byte.
// RULE_13: rx holding loads only while rx full clear; pending byte follows.
// RULE_14: firmware reads rx holding twice before a new transaction.
// RULE_15: with read-clears-both set, an rx read clears both flags.
// RULE_16: bit order is lsb first when set, msb first by default.
// RULE_17: active is high while shifting or a byte is queued; resets low.
// RULE_18: reserved bits read zero and ignore writes.
module sdb_top
(
	input  wire logic                       ref_clk,
	input  wire logic                       rst_n,
	input  wire logic                       clk_en,
	input  wire logic                       link_clk,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [sdb_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	input  wire logic [sdb_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	output logic [1:0]                      s_axi_bresp,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	input  wire logic [sdb_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic [sdb_pkg::DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            spi_sclk,
	output logic                            spi_mosi,
	input  wire logic                       spi_miso,
	output logic                            rx_irq_req,
	output logic                            tx_irq_req
);
	import sdb_pkg::*;

	// registers, next values and the events of each cycle
	logic              aw_held_q, w_held_q, wstrb0_q, tx_pend_q;
	logic              txe_q, busy_q, start_tgl_q, shift_lsb_q;
	logic              rxf_q, rx_pend_q, active_q, ctl_lsb_q;
	logic              ctl_rcb_q, done_prev_q, done_s, link_done_tgl;
	logic              wr_go, wr_tx, wr_ctl, rd_go, rd_rx, done_ev;
	logic              launch_dir, launch_pnd, launch;
	logic [ADDR_W-1:0] waddr_q;
	logic [7:0]        wbyte_q, tx_hold_q, shift_byte_q, rx_hold_q;
	logic [7:0]        rx_pend_byte_q, link_rx_byte, launch_byte;
	logic [DATA_W-1:0] rd_data_d;
	logic [1:0]        rd_resp_d, wr_resp_d;

	// ----------------------------------------------------------------
	// link side shifter and the return crossing
	// ----------------------------------------------------------------
	sdb_shifter u_shifter (.link_clk(link_clk), .rst_n(rst_n),
		.clk_en(clk_en), .start_tgl(start_tgl_q),
		.tx_byte(shift_byte_q), .lsb_first(shift_lsb_q),
		.miso(spi_miso), .sclk(spi_sclk), .mosi(spi_mosi),
		.rx_byte(link_rx_byte), .done_tgl(link_done_tgl));

	// rx byte is stable long before the toggle is seen here
	sdb_sync u_done (.clk(ref_clk), .d(link_done_tgl), .q(done_s));

	// ----------------------------------------------------------------
	// events of this cycle
	// ----------------------------------------------------------------
	assign wr_go      = clk_en && aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_tx      = wr_go && waddr_q == OFF_DATA && wstrb0_q;
	assign wr_ctl     = wr_go && waddr_q == OFF_CTRL && wstrb0_q;
	assign rd_go      = clk_en && s_axi_arvalid && s_axi_arready;
	assign rd_rx      = rd_go && s_axi_araddr == OFF_DATA;
	assign done_ev    = clk_en && (done_s ^ done_prev_q);
	assign launch_dir = wr_tx && !busy_q && !tx_pend_q;
	assign launch_pnd = clk_en && tx_pend_q && !busy_q;
	assign launch     = launch_dir || launch_pnd;
	assign launch_byte = launch_pnd ? tx_hold_q : wbyte_q;

	// ----------------------------------------------------------------
	// write channel: address and data taken in either order
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			waddr_q       <= '0;
			wbyte_q       <= 8'h00;
			wstrb0_q      <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end
		else if (clk_en)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q     <= 1'b1;
				s_axi_awready <= 1'b0;
				waddr_q       <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q     <= 1'b1;
				s_axi_wready <= 1'b0;
				wbyte_q      <= s_axi_wdata[7:0]; // [RULE_18]
				wstrb0_q     <= s_axi_wstrb[0];
			end
			if (wr_go)
			begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_resp_d;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// status is read only: writes there are accepted and dropped
	assign wr_resp_d = (waddr_q == OFF_DATA || waddr_q == OFF_STATUS
		|| waddr_q == OFF_CTRL) ? RESP_OKAY : RESP_SLVERR;

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_data_d = 32'h0000_0000; // [RULE_18]
		rd_resp_d = RESP_OKAY;
		case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
			OFF_DATA:   rd_data_d[7:0] = rx_hold_q;
			OFF_STATUS:
			begin
				rd_data_d[ST_TXE_BIT] = txe_q;
				rd_data_d[ST_RXF_BIT] = rxf_q;
				rd_data_d[ST_ACT_BIT] = active_q;
			end
			OFF_CTRL:
			begin
				rd_data_d[CT_LSB_BIT] = ctl_lsb_q;
				rd_data_d[CT_RCB_BIT] = ctl_rcb_q;
			end
			default:    rd_resp_d = RESP_SLVERR;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (clk_en)
		begin
			if (rd_go)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_data_d;
				s_axi_rresp   <= rd_resp_d;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// control bits: order and read-clears-both
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			ctl_lsb_q <= LSB_RST;
			ctl_rcb_q <= RCB_RST;
		end
		else if (wr_ctl)
		begin
			ctl_lsb_q <= wbyte_q[CT_LSB_BIT]; // [RULE_16]
			ctl_rcb_q <= wbyte_q[CT_RCB_BIT]; // [RULE_15]
		end
	end

	// ----------------------------------------------------------------
	// transmit path: holding byte, pending mark, shifter launch
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			tx_hold_q    <= 8'h00;
			tx_pend_q    <= 1'b0;
			busy_q       <= 1'b0;
			start_tgl_q  <= 1'b0;
			shift_byte_q <= 8'h00;
			shift_lsb_q  <= LSB_RST;
		end
		else if (clk_en)
		begin
			// a write while not empty overwrites the pending byte
			if (wr_tx)
				tx_hold_q <= wbyte_q;
			if (wr_tx && !launch_dir)
				tx_pend_q <= 1'b1; // [RULE_07]
			else if (launch_pnd)
				tx_pend_q <= 1'b0; // [RULE_08]
			if (launch)
			begin
				// byte and order are frozen for the whole transfer
				shift_byte_q <= launch_byte; // [RULE_05] [RULE_06]
				shift_lsb_q  <= ctl_lsb_q;
				start_tgl_q  <= ~start_tgl_q;
				busy_q       <= 1'b1;
			end
			else if (done_ev)
				busy_q <= 1'b0;
		end
	end

	// tx empty: set by a launch wins over any clear this cycle
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			txe_q <= TXE_RST; // [RULE_03]
		else if (clk_en)
		begin
			if (launch)
				txe_q <= 1'b1; // [RULE_06] [RULE_08]
			else if (wr_tx || (rd_rx && ctl_rcb_q))
				txe_q <= 1'b0; // [RULE_03] [RULE_15]
		end
	end

	// ----------------------------------------------------------------
	// receive path: holding byte plus one pending shift byte
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			rx_hold_q      <= 8'h00;
			rxf_q          <= RXF_RST;
			rx_pend_q      <= 1'b0;
			rx_pend_byte_q <= 8'h00;
			done_prev_q    <= 1'b0;
		end
		else if (clk_en)
		begin
			done_prev_q <= done_s;
			if (rd_rx && rx_pend_q)
			begin
				// pending byte moves up, flag stays set
				rx_hold_q <= rx_pend_byte_q; // [RULE_13]
				rx_pend_q <= done_ev;
				if (done_ev)
					rx_pend_byte_q <= link_rx_byte;
			end
			else if (done_ev && (!rxf_q || rd_rx))
			begin
				// arriving byte beats the clear of the same cycle
				rx_hold_q <= link_rx_byte; // [RULE_10] [RULE_13]
				rxf_q     <= 1'b1; // [RULE_01]
			end
			else if (done_ev)
			begin
				rx_pend_q      <= 1'b1; // [RULE_13]
				rx_pend_byte_q <= link_rx_byte;
			end
			else if (rd_rx)
				rxf_q <= 1'b0; // [RULE_01]
		end
	end

	// ----------------------------------------------------------------
	// active status and interrupt request levels
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			active_q   <= 1'b0;
			rx_irq_req <= RXF_RST;
			tx_irq_req <= TXE_RST;
		end
		else if (clk_en)
		begin
			active_q   <= busy_q || tx_pend_q || launch; // [RULE_17]
			rx_irq_req <= rxf_q; // [RULE_02]
			tx_irq_req <= txe_q; // [RULE_04]
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n || !clk_en);

	chk_rx_read_clear: assert property ( // [RULE_01]
		rd_rx && !rx_pend_q && !done_ev |=> !rxf_q)
		else $error("rx full not cleared by read");
	chk_tx_write_clear: assert property ( // [RULE_03]
		wr_tx && busy_q |=> !txe_q && tx_pend_q)
		else $error("tx empty not cleared by queued write");
	chk_idle_start: assert property ( // [RULE_05]
		launch_dir |=> busy_q && txe_q && start_tgl_q != $past(start_tgl_q))
		else $error("idle write did not start a transfer");
	chk_queue_hold: assert property ( // [RULE_07]
		tx_pend_q && busy_q && !done_ev |=> tx_pend_q && !txe_q)
		else $error("queued byte left holding early");
	chk_pend_launch: assert property ( // [RULE_08]
		launch_pnd && !wr_tx |=> busy_q && txe_q && !tx_pend_q
			&& shift_byte_q == $past(tx_hold_q))
		else $error("queued byte not loaded after shift end");
	chk_rx_load: assert property ( // [RULE_10]
		done_ev && !rxf_q |=> rxf_q && rx_hold_q == $past(link_rx_byte))
		else $error("finished byte not placed in rx holding");
	chk_rx_keep_full: assert property ( // [RULE_13]
		done_ev && rxf_q && !rd_rx && !rx_pend_q
			|=> rx_pend_q && rx_hold_q == $past(rx_hold_q) ##1 rxf_q)
		else $error("rx holding overwritten while full");
	chk_read_both: assert property ( // [RULE_15]
		rd_rx && ctl_rcb_q && !launch |=> !txe_q)
		else $error("read did not clear tx empty");
	chk_active_flag: assert property ( // [RULE_17]
		(busy_q || tx_pend_q) |=> active_q)
		else $error("active low while busy");
	chk_reserved_zero: assert property ( // [RULE_18]
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("reserved bits read nonzero");

	cov_queue_while_busy: cover property (wr_tx && busy_q);
	cov_rx_pending: cover property (done_ev && rxf_q && !rd_rx);
	cov_pending_drain: cover property (rd_rx && rx_pend_q);
	cov_read_both: cover property (rd_rx && ctl_rcb_q);

endmodule

// ===== tb/sdb_spi_slave.sv
// Purpose: behavioural serial slave that answers each byte with the last one, the first with FIRST_REPLY
// Assumes: mode 0 timing, sclk idle low, no chip select on this link
// Notes:   bit order follows lsb_first, which the bench sets with the control
`timescale 1ns/1ps
module sdb_spi_slave #(
	parameter logic [7:0] FIRST_REPLY = 8'h3C
)
(
	input  wire logic       rst_n,
	input  wire logic       sclk,
	input  wire logic       mosi,
	input  wire logic       lsb_first,
	output logic            miso,
	output logic [7:0]      got
);
	logic [2:0] idx_q;
	logic [7:0] shf_q;
	logic [7:0] prev_q;

	// ------------------------------------------------------------------
	// capture on rising sclk, advance on falling sclk
	// ------------------------------------------------------------------
	// echo of the previous frame: each reply after the first repeats the byte received in the frame before; the first is FIRST_REPLY
	always @(posedge sclk)
	begin
		shf_q <= lsb_first ? {mosi, shf_q[7:1]} : {shf_q[6:0], mosi};
	end

	// bit index wraps after eight falls, so frames stay aligned
	always @(negedge sclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			idx_q  <= 3'h0;
			prev_q <= FIRST_REPLY;
			got    <= 8'h00;
		end
		else
		begin
			idx_q <= idx_q + 3'h1;
			if (idx_q == 3'h7)
			begin
				prev_q <= shf_q;
				got    <= shf_q;
			end
		end
	end

	// reply bit is stable through the whole high half of sclk
	assign miso = lsb_first ? prev_q[idx_q] : prev_q[3'h7 - idx_q];
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the spi data buffer block
// Assumes: axi4-lite master tasks, serial slave model on the far side
// Notes:   reset held 2 cycles; its sync still reaches the link domain
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
	num_errors++; $display("[FAIL] %0t got %0h want %0h", $time, a, e); end end
module tb_top;
	import sdb_pkg::*;
	logic        ref_clk = 0, link_clk = 0, rst_n = 1, clk_en = 1;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0, slv_lsb = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, slv_got;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, spi_sclk, spi_mosi, spi_miso;
	logic        rx_irq_req, tx_irq_req;
	int          num_errors = 0, samples_checked = 0;

	always #5 ref_clk = ~ref_clk;
	initial #3 forever #6 link_clk = ~link_clk;

	sdb_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.link_clk(link_clk), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req));
	sdb_spi_slave slv (.rst_n(rst_n), .sclk(spi_sclk), .mosi(spi_mosi),
		.lsb_first(slv_lsb), .miso(spi_miso), .got(slv_got));

	// ------------------------------------------------------------------
	// bus tasks: valid held until its own ready edge
	// ------------------------------------------------------------------
	task automatic axw(input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] s, output logic [1:0] rs);
		logic aw_d, w_d, b_d;
		aw_d = 0; w_d = 0; b_d = 0; rs = 2'h3;
		s_axi_awvalid <= 1; s_axi_awaddr <= a; s_axi_bready <= 1;
		s_axi_wvalid <= 1; s_axi_wdata <= v; s_axi_wstrb <= s;
		for (int n = 0; n < 200 && !b_d; n++)
		begin
			@(posedge ref_clk);
			if (s_axi_bvalid && aw_d && w_d)
			begin
				rs = s_axi_bresp; b_d = 1; // bready stays high
			end
			if (s_axi_awready && !aw_d) begin aw_d = 1; s_axi_awvalid <= 0; end
			if (s_axi_wready && !w_d) begin w_d = 1; s_axi_wvalid <= 0; end
		end
		if (!b_d) `CHK(b_d, 1'b1)
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] rs);
		logic ar_d, r_d;
		ar_d = 0; r_d = 0; rs = 2'h3; v = 32'h0;
		s_axi_arvalid <= 1; s_axi_araddr <= a; s_axi_rready <= 1;
		for (int n = 0; n < 200 && !r_d; n++)
		begin
			@(posedge ref_clk);
			if (s_axi_rvalid && ar_d)
			begin
				v = s_axi_rdata; rs = s_axi_rresp; r_d = 1; // rready stays
			end
			if (s_axi_arready && !ar_d) begin ar_d = 1; s_axi_arvalid <= 0; end
		end
		if (!r_d) `CHK(r_d, 1'b1)
	endtask

	// polls status until a bit reaches a level, bounded
	task automatic wait_st(input int b, input logic lv);
		logic [31:0] st;
		logic [1:0]  rs;
		st = ~{32{lv}};
		for (int n = 0; n < 150 && st[b] !== lv; n++)
			axr(OFF_STATUS, st, rs);
		`CHK(st[b], lv)
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset;
		axr(OFF_STATUS, d, r); `CHK(d, 32'h1)
		`CHK(tx_irq_req, 1'b1)
		`CHK(rx_irq_req, 1'b0)
	endtask

	task automatic t_single;
		axw(OFF_DATA, 32'hFFFF_FFA5, 4'hF, r); // upper bits must be dropped
		axr(OFF_STATUS, d, r); `CHK(d, 32'h5)
		wait_st(ST_RXF_BIT, 1'b1);
		`CHK(rx_irq_req, 1'b1)
		`CHK(slv_got, 8'hA5)
		axr(OFF_DATA, d, r); `CHK(d, 32'h3C)
		axr(OFF_STATUS, d, r); `CHK(d, 32'h1)
		`CHK(rx_irq_req, 1'b0)
	endtask

	// second byte queued behind the first, receive left unread until both bytes are done
	task automatic t_queue;
		axw(OFF_DATA, 32'h5A, 4'h1, r);
		wait_st(ST_TXE_BIT, 1'b1);
		axw(OFF_DATA, 32'hC3, 4'h1, r);
		axr(OFF_STATUS, d, r); `CHK(d, 32'h4)
		`CHK(tx_irq_req, 1'b0)
		wait_st(ST_TXE_BIT, 1'b1);
		`CHK(slv_got, 8'h5A)
		wait_st(ST_ACT_BIT, 1'b0);
		`CHK(slv_got, 8'hC3)
		axr(OFF_STATUS, d, r); `CHK(d, 32'h3)
		axr(OFF_DATA, d, r); `CHK(d, 32'hA5)
		axr(OFF_STATUS, d, r); `CHK(d, 32'h3)
		axr(OFF_DATA, d, r); `CHK(d, 32'h5A)
		axr(OFF_STATUS, d, r); `CHK(d, 32'h1)
	endtask

	task automatic t_reserved;
		axw(OFF_STATUS, 32'h0, 4'hF, r); `CHK(r, RESP_OKAY)
		axw(8'h10, 32'h1, 4'hF, r); `CHK(r, RESP_SLVERR)
		axr(8'h10, d, r); `CHK(r, RESP_SLVERR)
		axw(OFF_DATA, 32'h77, 4'hE, r); // lane 0 off: no transfer
		axw(OFF_CTRL, 32'hFFFF_FFFC, 4'hF, r);
		axr(OFF_CTRL, d, r); `CHK(d, 32'h0)
		axr(OFF_STATUS, d, r); `CHK(d, 32'h1)
	endtask

	// read-clears-both is left set, so this runs last
	task automatic t_lsb_both;
		axw(OFF_CTRL, 32'h3, 4'hF, r);
		slv_lsb <= 1'b1;
		axw(OFF_DATA, 32'h1E, 4'h1, r);
		wait_st(ST_RXF_BIT, 1'b1);
		`CHK(slv_got, 8'h1E)
		axr(OFF_DATA, d, r); `CHK(d, 32'hC3)
		axr(OFF_STATUS, d, r); `CHK(d, 32'h0)
	endtask

	task automatic summarize;
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------------
	initial
	begin
		// the fall at time zero also clears the slave model
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_reset;
		t_single;
		t_queue;
		t_reserved;
		t_lsb_both;
		summarize;
	end

	// the whole run needs well under 20000 cycles
	initial
	begin
		#200000;
		num_errors++;
		summarize;
	end
endmodule
